/* File: src/p3hs_pkg.sv */
package p3hs_pkg;
  // Register file addresses
  localparam logic [7:0] DATA_ADDR       = 8'h03;
  localparam logic [7:0] PORT_BASE_ADDR  = 8'h00;
  localparam logic [7:0] MODE_ADDR       = 8'hF7;
  localparam logic [7:0] BYTE_MODE_ADDR  = 8'hF8;
  localparam logic [7:0] P2_DIR_ADDR     = 8'hF6;
  localparam logic [7:0] CONFIG_ADDR     = 8'h00;
  // Mode register fields
  localparam int MODE_ANALOG_BIT   = 1;
  localparam int MODE_P0HS_BIT     = 2;
  localparam int MODE_P1HS_LO_BIT  = 3;
  localparam int MODE_P1HS_HI_BIT  = 4;
  localparam int MODE_P0HS_HI_BIT  = 5;
  localparam int MODE_P2HS_BIT     = 6;
  localparam logic [7:0] MODE_SPECIAL_MASK = 8'h7E;
  // Byte port direction fields
  localparam int BYTE_P0_DIR_BIT   = 6;
  localparam int BYTE_P1_DIR_BIT   = 3;
  localparam int P2_DIR_MSB_BIT    = 7;
  // Port configuration fields
  localparam int CONFIG_CMP_OUT_BIT = 0;
  // Reset values
  localparam logic [7:0] MODE_RESET      = 8'h00;
  localparam logic [7:0] BYTE_MODE_RESET = 8'h4D;
  localparam logic [7:0] P2_DIR_RESET    = 8'hFF;
  localparam logic [7:0] CONFIG_RESET    = 8'hFE;
  localparam logic [7:0] OUT_RESET       = 8'hF0;
  // Handshake states
  typedef enum logic [3:0] {
    P3HS_IDLE    = 4'h1,
    P3HS_WAIT_ACK = 4'h2,
    P3HS_WAIT_END = 4'h4,
    P3HS_HOLD    = 4'h8
  } p3hs_state_type;
endpackage

/* File: src/p3hs_port.sv */
`timescale 1ns/1ps
module p3hs_port #(
  parameter int NUM_PORTS = 3,
  parameter int DATA_W    = 8
) (
  // Clock and reset
  input  wire logic                      i_clock,
  input  wire logic                      i_resetn,
  input  wire logic                      i_stop_recovery_wdt,
  // Register file access
  input  wire logic [7:0]                i_reg_addr,
  input  wire logic                      i_reg_write,
  input  wire logic                      i_reg_read,
  input  wire logic                      i_config_write,
  input  wire logic [7:0]                i_reg_wdata,
  output logic      [7:0]                o_reg_rdata,
  // Control port pins
  input  wire logic [3:0]                i_input_lines,
  output logic      [3:0]                o_output_lines,
  input  wire logic [1:0]                i_comparator_out,
  output logic      [3:0]                o_interrupt_request,
  // Byte ports 0..2
  input  wire logic [NUM_PORTS*DATA_W-1:0] i_port_pins,
  output logic      [NUM_PORTS*DATA_W-1:0] o_port_in_data,
  output logic      [NUM_PORTS*DATA_W-1:0] o_port_out_data,
  output logic      [NUM_PORTS-1:0]        o_port_hs_output
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                      rst_sync;
    logic [7:0]                      mode;
    logic [7:0]                      byte_mode;
    logic [7:0]                      p2_dir;
    logic [7:0]                      config_bits;
    logic [7:0]                      out_reg;
    logic [NUM_PORTS-1:0]            hs_line;
    logic [NUM_PORTS-1:0]            in_prev;
    logic [NUM_PORTS-1:0]            wr_pend;
    logic [NUM_PORTS*DATA_W-1:0]     in_data;
    logic [NUM_PORTS*DATA_W-1:0]     out_data;
    logic [NUM_PORTS*DATA_W-1:0]     pin_data;
    p3hs_pkg::p3hs_state_type        [NUM_PORTS-1:0] st;
    logic [7:0]                      rdata;
    logic [3:0]                      lines_out;
    logic [3:0]                      irq;
  } p3hs_regs_type;

  // Local names for the handshake states
  localparam p3hs_pkg::p3hs_state_type P3HS_IDLE     = p3hs_pkg::P3HS_IDLE;
  localparam p3hs_pkg::p3hs_state_type P3HS_WAIT_ACK = p3hs_pkg::P3HS_WAIT_ACK;
  localparam p3hs_pkg::p3hs_state_type P3HS_WAIT_END = p3hs_pkg::P3HS_WAIT_END;
  localparam p3hs_pkg::p3hs_state_type P3HS_HOLD     = p3hs_pkg::P3HS_HOLD;

  p3hs_regs_type state_reg;
  p3hs_regs_type state_next;

  // ----------------------------------------------------------------
  // Line and address mapping
  // ----------------------------------------------------------------
  // Byte port p is reached at its own register file address
  function automatic logic [7:0] p3hs_port_addr(input int p);
    p3hs_port_addr = p3hs_pkg::PORT_BASE_ADDR + 8'(p);
  endfunction

  // Input line index and output line index for each port
  function automatic int p3hs_in_idx(input int p);
    case (p)
      0:       p3hs_in_idx = 2;
      1:       p3hs_in_idx = 3;
      default: p3hs_in_idx = 1;
    endcase
  endfunction

  function automatic int p3hs_out_idx(input int p);
    case (p)
      0:       p3hs_out_idx = 1;
      1:       p3hs_out_idx = 0;
      default: p3hs_out_idx = 2;
    endcase
  endfunction

  // Interrupt request number fed by each input line
  function automatic int p3hs_irq_idx(input int line);
    case (line)
      0:       p3hs_irq_idx = 3;
      1:       p3hs_irq_idx = 2;
      2:       p3hs_irq_idx = 0;
      default: p3hs_irq_idx = 1;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [NUM_PORTS-1:0] hs_en;
  logic [NUM_PORTS-1:0] hs_is_input;
  logic [3:0]           hs_out_mask;
  logic                 rst_n;
  logic                 data_wr;
  logic [NUM_PORTS-1:0] port_wr;
  logic [NUM_PORTS-1:0] port_rd;
  logic [3:0]           lines_next;
  logic [3:0]           lines_reg;

  assign rst_n = state_reg.rst_sync[1];
  assign data_wr = i_reg_write && (i_reg_addr == p3hs_pkg::DATA_ADDR);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb begin
    hs_en[0] = state_reg.mode[p3hs_pkg::MODE_P0HS_BIT];
    hs_en[1] = state_reg.mode[p3hs_pkg::MODE_P1HS_HI_BIT]
             && state_reg.mode[p3hs_pkg::MODE_P1HS_LO_BIT];
    hs_en[2] = state_reg.mode[p3hs_pkg::MODE_P2HS_BIT];
    hs_is_input[0] = state_reg.byte_mode[p3hs_pkg::BYTE_P0_DIR_BIT];
    hs_is_input[1] = state_reg.byte_mode[p3hs_pkg::BYTE_P1_DIR_BIT];
    hs_is_input[2] = state_reg.p2_dir[p3hs_pkg::P2_DIR_MSB_BIT];
    hs_out_mask = 4'h0;
    // Byte port data strobes; the handshakes follow reads and writes of these
    for (int p = 0; p < NUM_PORTS; p++) begin
      port_wr[p] = i_reg_write && (i_reg_addr == p3hs_port_addr(p));
      port_rd[p] = i_reg_read && (i_reg_addr == p3hs_port_addr(p));
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (hs_en[p]) begin
        hs_out_mask[p3hs_out_idx(p)] = 1'b1;
      end
    end
  end

  always_comb begin
    logic [3:0] lines;
    logic       hin;
    logic       cmp_on;
    state_next = state_reg;
    lines = 4'h0;
    hin = 1'b0;
    cmp_on = state_reg.mode[p3hs_pkg::MODE_ANALOG_BIT]
           && state_reg.config_bits[p3hs_pkg::CONFIG_CMP_OUT_BIT];
    state_next.rst_sync = {state_reg.rst_sync[0], 1'b1};
    state_next.irq = 4'h0;
    // Register writes; a stop-recovery timeout keeps mode, direction and config, not data or port writes
    if (!i_stop_recovery_wdt && i_reg_write) begin
      case (i_reg_addr)
        p3hs_pkg::MODE_ADDR:      state_next.mode = i_reg_wdata;
        p3hs_pkg::BYTE_MODE_ADDR: state_next.byte_mode = i_reg_wdata;
        p3hs_pkg::P2_DIR_ADDR:    state_next.p2_dir = i_reg_wdata;
        default: begin
        end
      endcase
    end
    if (!i_stop_recovery_wdt && i_config_write) begin
      state_next.config_bits = i_reg_wdata;
    end
    if (data_wr) begin
      // Handshake outputs are masked from software writes
      state_next.out_reg = (state_reg.out_reg & {hs_out_mask, 4'h0})
                         | (i_reg_wdata & ~{hs_out_mask, 4'h0});
    end
    // Plain interrupt requests on falling input edges
    for (int l = 0; l < 4; l++) begin
      if (state_reg.lines_out[l] && !i_input_lines[l]) begin
        state_next.irq[p3hs_irq_idx(l)] = 1'b1;
      end
    end
    state_next.lines_out = i_input_lines;
    // Handshake engines
    for (int p = 0; p < NUM_PORTS; p++) begin
      hin = i_input_lines[p3hs_in_idx(p)];
      state_next.in_prev[p] = hin;
      if (!hs_en[p]) begin
        state_next.st[p] = P3HS_IDLE;
        state_next.hs_line[p] = 1'b1;
        state_next.wr_pend[p] = 1'b0;
        state_next.pin_data[p*DATA_W +: DATA_W] = i_port_pins[p*DATA_W +: DATA_W];
        if (port_wr[p]) begin
          state_next.out_data[p*DATA_W +: DATA_W] = i_reg_wdata;
        end
      end else if (hs_is_input[p]) begin
        case (state_reg.st[p])
          P3HS_IDLE: begin
            state_next.hs_line[p] = 1'b1;
            if (!hin) begin
              state_next.in_data[p*DATA_W +: DATA_W] = i_port_pins[p*DATA_W +: DATA_W];
              state_next.irq[p3hs_irq_idx(p3hs_in_idx(p))] = 1'b1;
              state_next.hs_line[p] = 1'b0;
              state_next.st[p] = P3HS_HOLD;
            end
          end
          P3HS_HOLD: begin
            if (port_rd[p]) begin
              state_next.st[p] = P3HS_WAIT_END;
            end
          end
          P3HS_WAIT_END: begin
            if (hin) begin
              state_next.hs_line[p] = 1'b1;
              state_next.st[p] = P3HS_IDLE;
            end
          end
          default: state_next.st[p] = P3HS_IDLE;
        endcase
      end else begin
        if (port_wr[p]) begin
          state_next.out_data[p*DATA_W +: DATA_W] = i_reg_wdata;
          state_next.wr_pend[p] = 1'b1;
        end
        case (state_reg.st[p])
          P3HS_IDLE: begin
            state_next.hs_line[p] = 1'b1;
            if ((state_reg.wr_pend[p] || port_wr[p]) && hin) begin
              state_next.pin_data[p*DATA_W +: DATA_W] = port_wr[p] ? i_reg_wdata
                  : state_reg.out_data[p*DATA_W +: DATA_W];
              state_next.hs_line[p] = 1'b0;
              state_next.wr_pend[p] = 1'b0;
              state_next.st[p] = P3HS_WAIT_ACK;
            end
          end
          P3HS_WAIT_ACK: begin
            if (!hin) begin
              state_next.irq[p3hs_irq_idx(p3hs_in_idx(p))] = 1'b1;
              state_next.hs_line[p] = 1'b1;
              state_next.st[p] = P3HS_WAIT_END;
            end
          end
          P3HS_WAIT_END: begin
            if (hin) begin
              state_next.st[p] = P3HS_IDLE;
            end
          end
          default: state_next.st[p] = P3HS_IDLE;
        endcase
      end
    end
    // Output line selection: plain, handshake or comparator
    lines = state_reg.out_reg[7:4];
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (hs_en[p]) begin
        lines[p3hs_out_idx(p)] = state_reg.hs_line[p];
      end
    end
    if (cmp_on) begin
      lines[0] = i_comparator_out[0];
      lines[1] = i_comparator_out[1];
      lines[3] = i_comparator_out[1];
    end
    state_next.rdata = {lines, i_input_lines};
    state_next.lines_out = i_input_lines;
    state_next.out_data = state_next.out_data;
    state_next.mode = state_next.mode;
    state_next.irq = state_next.irq;
    state_next.rst_sync = state_next.rst_sync;
    state_next.config_bits = state_next.config_bits;
    state_next.byte_mode = state_next.byte_mode;
    state_next.p2_dir = state_next.p2_dir;
    state_next.hs_line = state_next.hs_line;
    state_next.in_data = state_next.in_data;
    lines_next = lines;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      lines_reg <= p3hs_pkg::OUT_RESET[7:4];
    end else begin
      lines_reg <= lines_next;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg             <= '0;
      state_reg.mode        <= p3hs_pkg::MODE_RESET;
      state_reg.byte_mode   <= p3hs_pkg::BYTE_MODE_RESET;
      state_reg.p2_dir      <= p3hs_pkg::P2_DIR_RESET;
      state_reg.config_bits <= p3hs_pkg::CONFIG_RESET;
      state_reg.out_reg     <= p3hs_pkg::OUT_RESET;
      state_reg.hs_line     <= '1;
      state_reg.in_prev     <= '1;
      state_reg.lines_out   <= '1;
      for (int p = 0; p < NUM_PORTS; p++) begin
        state_reg.st[p] <= P3HS_IDLE;
      end
    end else if (!rst_n) begin
      state_reg.rst_sync <= state_next.rst_sync;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a flop; the comparator mux sits before lines_reg
  assign o_reg_rdata         = state_reg.rdata;
  assign o_output_lines      = lines_reg;
  assign o_interrupt_request = state_reg.irq;
  assign o_port_in_data      = state_reg.in_data;
  assign o_port_out_data     = state_reg.pin_data;
  assign o_port_hs_output    = state_reg.hs_line;

endmodule

/* File: verification/p3hs_port_asserts.sv */
`timescale 1ns/1ps
module p3hs_port_asserts #(
  parameter int NUM_PORTS = 3,
  parameter int DATA_W    = 8
) (
  // Clock and reset
  input wire logic                        i_clock,
  input wire logic                        i_resetn,
  // Watched ports
  input wire logic [3:0]                  i_input_lines,
  input wire logic [NUM_PORTS*DATA_W-1:0] i_port_pins,
  input wire logic [7:0]                  o_reg_rdata,
  input wire logic [3:0]                  o_output_lines,
  input wire logic [3:0]                  o_interrupt_request,
  input wire logic [NUM_PORTS*DATA_W-1:0] o_port_in_data,
  input wire logic [NUM_PORTS-1:0]        o_port_hs_output
);
  // ----------------------------------------
  // Port 2 handshake and request routing
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  wire [DATA_W-1:0] p2_pins = i_port_pins[2*DATA_W +: DATA_W];
  wire [DATA_W-1:0] p2_in   = o_port_in_data[2*DATA_W +: DATA_W];
  wire              p2_hs   = o_port_hs_output[2];

  interrupt_request_3_map_a: assert property ($fell(i_input_lines[0]) |-> ##[1:3] o_interrupt_request[3])
    else $error("input 0 fall gave no request 3");
  interrupt_request_2_map_a: assert property ($fell(i_input_lines[1]) |-> ##[1:3] o_interrupt_request[2])
    else $error("input 1 fall gave no request 2");
  interrupt_request_0_map_a: assert property ($fell(i_input_lines[2]) |-> ##[1:3] o_interrupt_request[0])
    else $error("input 2 fall gave no request 0");
  interrupt_request_1_map_a: assert property ($fell(i_input_lines[3]) |-> ##[1:3] o_interrupt_request[1])
    else $error("input 3 fall gave no request 1");
  read_pins_a: assert property ($stable(i_input_lines) [*5] |-> o_reg_rdata[3:0] == i_input_lines)
    else $error("read data misses input levels");
  in_latch_a: assert property ($fell(p2_hs) && !$past(i_input_lines[1]) |-> p2_in == $past(p2_pins))
    else $error("strobe did not latch port data");
  in_protect_a: assert property (!p2_hs && !$past(p2_hs) |-> $stable(p2_in))
    else $error("latched data overwritten");
  hs_pin_a: assert property ($fell(p2_hs) |-> ##[0:1] !o_output_lines[2])
    else $error("handshake not on output 6");

  cover property ($fell(p2_hs));
  cover property ($rose(p2_hs));
  cover property (o_interrupt_request[2]);
endmodule

bind p3hs_port p3hs_port_asserts #(.NUM_PORTS(NUM_PORTS), .DATA_W(DATA_W)) u_chk (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_input_lines(i_input_lines),
  .i_port_pins(i_port_pins), .o_reg_rdata(o_reg_rdata), .o_output_lines(o_output_lines),
  .o_interrupt_request(o_interrupt_request), .o_port_in_data(o_port_in_data),
  .o_port_hs_output(o_port_hs_output));

/* File: verification/p3hs_periph.sv */
`timescale 1ns/1ps
module p3hs_periph (
  // Clock
  input  wire logic       i_clock,
  // Bench control
  input  wire logic       i_recv,
  input  wire logic       i_send,
  input  wire logic       i_stall,
  input  wire logic [7:0] i_byte,
  // Device side
  input  wire logic       i_hs_line,
  input  wire logic [7:0] i_dev_data,
  output logic            o_hs_line,
  output logic      [7:0] o_pins,
  output logic      [7:0] o_got
);
  initial begin
    o_hs_line = 1'b1;
    o_pins    = 8'h00;
    o_got     = 8'h00;
  end
  // Released pins flip so stale data never looks valid
  always @(posedge i_clock) begin
    if (i_recv) begin
      if (o_hs_line && !i_hs_line) begin
        o_got     <= i_dev_data;
        o_hs_line <= 1'b0;
      end else if (!o_hs_line && i_hs_line && !i_stall) begin
        o_hs_line <= 1'b1;
      end
    end else if (!o_hs_line && !i_hs_line) begin
      o_hs_line <= 1'b1;
      o_pins    <= ~o_pins;
    end else if (i_send && o_hs_line) begin
      o_pins    <= i_byte;
      o_hs_line <= 1'b0;
    end
  end
endmodule

/* File: verification/p3hs_port_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module p3hs_port_tb;
  logic       clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, cfg_wr = 1'b0, wdt = 1'b0;
  logic       p_recv = 1'b0, p_send = 1'b0, p_stall = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, p_byte = 8'h00;
  logic [1:0] cmp = 2'h0;
  logic [3:0] lines = 4'hF, seen = 4'h0;
  int         errors = 0, n_tests = 0, cycles = 0;
  wire [7:0]  rdata, p_pins, got;
  wire [3:0]  olines, irq;
  wire [23:0] in_data, out_data;
  wire [2:0]  hs;
  wire        hs_line;

  always #50 clk = ~clk;

  p3hs_port u_dut (.i_clock(clk), .i_resetn(rstn), .i_stop_recovery_wdt(wdt),
    .i_reg_addr(addr), .i_reg_write(wr), .i_reg_read(rd), .i_config_write(cfg_wr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_input_lines({lines[3:2], lines[1] & hs_line, lines[0]}), .o_output_lines(olines),
    .i_comparator_out(cmp), .o_interrupt_request(irq), .i_port_pins({p_pins, 16'h0000}),
    .o_port_in_data(in_data), .o_port_out_data(out_data), .o_port_hs_output(hs));

  p3hs_periph u_periph (.i_clock(clk), .i_recv(p_recv), .i_send(p_send), .i_stall(p_stall),
    .i_byte(p_byte), .i_hs_line(hs[2]), .i_dev_data(out_data[23:16]), .o_hs_line(hs_line),
    .o_pins(p_pins), .o_got(got));

  // ----------------------------------------
  // Bus and handshake helpers
  // ----------------------------------------
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= w; rd <= !w;
    @(posedge clk);
    wr <= 1'b0; rd <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    p_byte <= b; p_send <= 1'b1;
    @(posedge clk);
    p_send <= 1'b0;
  endtask
  task automatic wait_hs(input logic v);
    logic hit;
    hit = 1'b0;
    repeat (20) begin
      @(negedge clk);
      seen |= irq;
      if (hs[2] === v) begin
        hit = 1'b1;
        break;
      end
    end
    repeat (2) begin
      @(negedge clk);
      seen |= irq;
    end
    `CHK(hit, 1'b1)
  endtask

  task automatic tally_and_finish();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    @(negedge clk);
    `CHK({olines, irq, hs}, {4'hF, 4'h0, 3'h7})
  endtask
  task automatic t_plain();
    access(1'b1, p3hs_pkg::DATA_ADDR, 8'hA5);
    access(1'b1, 8'h55, 8'h00);
    repeat (3) @(negedge clk);
    `CHK(olines, 4'hA)
    `CHK(rdata, 8'hAF)
    access(1'b1, p3hs_pkg::DATA_ADDR, 8'hF0);
  endtask
  task automatic t_irq();
    logic [1:0] dst [4] = '{2'd3, 2'd2, 2'd0, 2'd1};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      lines[i] <= 1'b0;
      seen = 4'h0;
      repeat (4) begin
        @(negedge clk);
        seen |= irq;
      end
      `CHK(seen, 4'h1 << dst[i])
      @(posedge clk);
      lines[i] <= 1'b1;
      @(posedge clk);
    end
  endtask
  task automatic t_in_hs();
    access(1'b1, p3hs_pkg::MODE_ADDR, 8'h40);
    seen = 4'h0;
    send(8'h3C);
    wait_hs(1'b0);
    `CHK(in_data[23:16], 8'h3C)
    `CHK(seen[2], 1'b1)
    send(8'hC3);
    repeat (4) @(negedge clk);
    `CHK({in_data[23:16], hs[2]}, {8'h3C, 1'b0})
    access(1'b0, 8'h02, 8'h00);
    wait_hs(1'b1);
    access(1'b1, p3hs_pkg::DATA_ADDR, 8'h80);
    repeat (3) @(negedge clk);
    `CHK(olines, 4'hC)
  endtask
  task automatic t_out_hs();
    @(posedge clk);
    p_recv <= 1'b1; p_stall <= 1'b1;
    access(1'b1, p3hs_pkg::P2_DIR_ADDR, 8'h00);
    seen = 4'h0;
    access(1'b1, 8'h02, 8'h5A);
    wait_hs(1'b0);
    `CHK(out_data[23:16], 8'h5A)
    wait_hs(1'b1);
    `CHK({seen[2], got}, {1'b1, 8'h5A})
    access(1'b1, 8'h02, 8'hA6);
    repeat (3) @(negedge clk);
    `CHK(out_data[23:16], 8'h5A)
    @(posedge clk);
    p_stall <= 1'b0;
    wait_hs(1'b0);
    `CHK(out_data[23:16], 8'hA6)
    repeat (5) @(negedge clk);
    `CHK({got, hs[2]}, {8'hA6, 1'b1})
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_plain();
    t_irq();
    t_in_hs();
    t_out_hs();
    tally_and_finish();
  end
endmodule
